// ### pmc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_cpu_model (
    input  wire logic        clk_in,
    input  wire logic        dstop_n_in,
    input  wire logic        scpu_n_in,
    input  wire logic        sclk_n_in,
    output logic [15:0]      gap_a_out,
    output logic [15:0]      gap_b_out
);
    logic [15:0] cnt = 16'h0000;
    logic [2:0]  prev = 3'h7;
    // ==========
    // cpu side: times each sideband release against the one before
    always_ff @(posedge clk_in) begin
        prev <= {dstop_n_in, scpu_n_in, sclk_n_in};
        cnt <= cnt + 16'h0001;
        if (dstop_n_in && !prev[2]) begin
            cnt <= 16'h0001;
        end
        if (scpu_n_in && !prev[1]) begin
            gap_a_out <= cnt;
            cnt <= 16'h0001;
        end
        if (sclk_n_in && !prev[0]) begin
            gap_b_out <= cnt;
        end
    end
endmodule : pmc_cpu_model
`default_nettype wire

// ### pmc_pkg.sv
// Summary of operation
// RL1: flag deep C-state entered while config unlocked
// RL2: S4 stretch lock sets on 1, freezes fields
// RL3: base lock sets on 1, platform reset clears
// RL4: C-state lock freezes timing registers, outside bits
// RL5: deep exit timing resets 13h, bit6 slow
// RL6: bits 5:3 pace sync to stop-clock release
// RL7: bits 2:0 pace deeper-stop to stop-cpu release
// RL8: popup moves C3/C4 to C2, else break
// RL9: popdown returns to C3/C4 when masters idle
// RL10: software keeps popdown clear while popup clear
// RL11: suppress bit blocks bus master activity flag
// RL12: force bit makes C4 exit slow always
// RL13: bits 3:2 pace regulator to stop-cpu release
// RL14: bits 1:0 pick message delay, zero uses PLL
// RL15: enabled sources always set flag and break
// RL16: reset-port lock freezes itself and select
// RL17: select widens reset-port reset to global
// RL18: firmware writes bit 30 and bits 9:8; code stores bits 1:0 of OFS_INIT in place of 9:8
// RL19: two-bit route picks SMI or SCI per GPIO
// RL20: sleeping GPIO with event enable can wake
// RL21: command port write stores, may raise SMI
// RL22: scratch port plain byte, cleared by reset
// RL23: S4 lock freezes width 5:4 and stretch 3
// RL24: frozen fields keep value, read back frozen
package pmc_pkg;
    // ==========
    // register map
    localparam logic [15:0] OFS_CFG3 = 16'h00A4;
    localparam logic [15:0] OFS_LOCK = 16'h00A6;
    localparam logic [15:0] OFS_DEEP = 16'h00A8;
    localparam logic [15:0] OFS_MODE = 16'h00A9;
    localparam logic [15:0] OFS_C4   = 16'h00AA;
    localparam logic [15:0] OFS_BRK  = 16'h00AB;
    localparam logic [15:0] OFS_INIT = 16'h00AC;
    localparam logic [15:0] OFS_GPIO = 16'h00B8;
    localparam logic [15:0] IO_CMD   = 16'h00B2;
    localparam logic [15:0] IO_SCR   = 16'h00B3;
    localparam logic [15:0] IO_RST   = 16'h0CF9;
    localparam logic [7:0]  DEEP_RST = 8'h13;
    localparam logic [7:0]  RST_CMD_A = 8'h06;
    localparam logic [7:0]  RST_CMD_B = 8'h0E;
    // ==========
    // field positions
    localparam int LCK_CST = 0;
    localparam int LCK_BASE = 1;
    localparam int LCK_S4 = 2;
    localparam int LCK_UNL = 7;
    localparam int MODE_SUPP = 2;
    localparam int MODE_PUP = 3;
    localparam int MODE_PDN = 4;
    localparam logic [7:0] BRK_MASK = 8'hE7;
    localparam logic [7:0] C4_MASK = 8'hCF;
    localparam logic [7:0] DEEP_MASK = 8'h7F;
    // ==========
    // timing
    localparam int CLK_NS = 10;
    localparam int PCI_NS = 30;
    localparam int US_CYC = 1000 / CLK_NS;
    localparam int SYNC_PCI = 16;
    localparam int SYNC_PCI_CYC = (SYNC_PCI * PCI_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_US [8] = '{0, 80, 99, 118, 18, 38, 56, 199};
    localparam int DSTOP_US [8] = '{22, 34, 56, 95, 199, 138, 72, 199};
    localparam int VREG_US [4] = '{95, 22, 95, 95};
    localparam int MSG_US [4] = '{30, 20, 15, 10};
    localparam int PLL_US [4] = '{30, 30, 30, 30};

    typedef struct packed {
        logic       rsv;
        logic       slow;
        logic [2:0] sync_dly;
        logic [2:0] stop_dly;
    } pmc_deep_s;

    typedef struct packed {
        logic       force_slow;
        logic       slow;
        logic [1:0] rsv;
        logic [1:0] vr_dly;
        logic [1:0] msg_dly;
    } pmc_c4_s;

    typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_EXIT1, ST_EXIT2}
        pmc_seq_e;

    function automatic logic [15:0] us_cyc(input int us);
        return 16'(us * US_CYC);
    endfunction : us_cyc
endpackage : pmc_pkg

// ### pmc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_regs (
    input  wire logic        MCLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        CFG_WR_IN,
    input  wire logic        CFG_RD_IN,
    input  wire logic        IO_WR_IN,
    input  wire logic        IO_RD_IN,
    input  wire logic [15:0] ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    input  wire logic        RST_PORT_RESET_IN,
    input  wire logic [2:0]  CPU_CSTATE_IN,
    input  wire logic [7:0]  BM_REQ_IN,
    input  wire logic        CX_ENTER_IN,
    input  wire logic        CX_DEEP_IN,
    input  wire logic        CX_EXIT_IN,
    input  wire logic [1:0]  PLL_LOCK_TIME_IN,
    input  wire logic        CMD_PORT_EN_IN,
    input  wire logic [15:0] GPIO_STS_IN,
    input  wire logic [15:0] GPIO_IS_INPUT_IN,
    input  wire logic [15:0] ALT_SMI_EN_IN,
    input  wire logic [15:0] GPE_EN_IN,
    input  wire logic        SLEEPING_IN,
    output logic [7:0]       RDATA_OUT,
    output logic             RVALID_OUT,
    output logic             CSTATE_LOCK_OUT,
    output logic             BASE_LOCK_OUT,
    output logic [1:0]       S4_WIDTH_OUT,
    output logic             S4_STRETCH_OUT,
    output logic             BM_FLAG_SET_OUT,
    output logic             BREAK_C0_OUT,
    output logic             POPUP_C2_OUT,
    output logic             POPDOWN_OUT,
    output logic             BM_AUTO_EN_OUT,
    output logic             POWER_SYNC_N_OUT,
    output logic             STOP_CLOCK_N_OUT,
    output logic             DEEPER_STOP_N_OUT,
    output logic             STOP_CPU_N_OUT,
    output logic             REGULATOR_SLEEP_OUT,
    output logic             DEEP_SLEEP_N_OUT,
    output logic             MEM_MSG_OUT,
    output logic             CMD_SMI_OUT,
    output logic             GPIO_SMI_OUT,
    output logic             GPIO_SCI_OUT,
    output logic             GPIO_WAKE_OUT,
    output logic             HOST_RESET_OUT,
    output logic             GLOBAL_RESET_OUT
);
    import pmc_pkg::*;

    // ==========
    // register storage
    logic [7:0]  lock_ctl;
    pmc_deep_s   deep_t;
    logic [7:0]  mode_cfg;
    pmc_c4_s     c4_t;
    logic [7:0]  brk_en;
    logic        rp_lock;
    logic        glob_sel;
    logic        init_f2;
    logic [1:0]  init_f0;
    logic [7:0]  cmd_port;
    logic [7:0]  scr_port;
    logic [31:0] gpio_route;
    logic [2:0]  s4_fld;

    logic cw;
    logic iw;
    assign cw = CFG_WR_IN;
    assign iw = IO_WR_IN;

    // lock bits only ever set by software; clear is by reset alone
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            lock_ctl <= 8'h00;
        end else begin
            if (cw && ADDR_IN == OFS_LOCK) begin
                lock_ctl[LCK_CST]  <= lock_ctl[LCK_CST] | WDATA_IN[LCK_CST];
                lock_ctl[LCK_BASE] <= lock_ctl[LCK_BASE] | WDATA_IN[LCK_BASE]; // RL3
                lock_ctl[LCK_S4]   <= lock_ctl[LCK_S4] | WDATA_IN[LCK_S4]; // RL2
            end
            // software writes never reach this flag
            if (CPU_CSTATE_IN > 3'h2 && !lock_ctl[LCK_CST]) begin
                lock_ctl[LCK_UNL] <= 1'b1; // RL1
            end
        end
    end

    // stretch fields frozen under the S4 lock
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            s4_fld <= 3'h0;
        end else if (cw && ADDR_IN == OFS_CFG3 && !lock_ctl[LCK_S4]) begin
            s4_fld <= WDATA_IN[5:3]; // RL23 RL24
        end
    end

    // timing registers frozen under the C-state lock
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            deep_t <= pmc_deep_s'(DEEP_RST); // RL5
            c4_t   <= pmc_c4_s'(8'h00);
        end else if (cw && !lock_ctl[LCK_CST]) begin
            if (ADDR_IN == OFS_DEEP) begin
                deep_t <= pmc_deep_s'(WDATA_IN & DEEP_MASK); // RL4 RL24
            end
            if (ADDR_IN == OFS_C4) begin
                c4_t <= pmc_c4_s'(WDATA_IN & C4_MASK); // RL4 RL24
            end
        end
    end

    // mode and break enables, plain read/write
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            mode_cfg <= 8'h00;
            brk_en   <= 8'h00;
        end else if (cw) begin
            if (ADDR_IN == OFS_MODE) begin
                mode_cfg <= WDATA_IN & 8'h9C;
            end
            if (ADDR_IN == OFS_BRK) begin
                brk_en <= WDATA_IN & BRK_MASK;
            end
        end
    end

    // init register; the reset-port reset clears only the lock
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            rp_lock  <= 1'b0;
            glob_sel <= 1'b0;
            init_f2  <= 1'b0;
            init_f0  <= 2'h0;
        end else if (RST_PORT_RESET_IN) begin
            rp_lock <= 1'b0; // RL16
        end else if (cw) begin
            if (ADDR_IN == OFS_INIT) begin
                init_f0 <= WDATA_IN[1:0];
            end
            if (ADDR_IN == OFS_INIT + 16'h0002 && !rp_lock) begin
                glob_sel <= WDATA_IN[4]; // RL16
            end
            if (ADDR_IN == OFS_INIT + 16'h0003) begin
                init_f2 <= WDATA_IN[6];
                rp_lock <= rp_lock | WDATA_IN[7]; // RL16
            end
        end
    end

    // gpio routing, one byte lane per write
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            gpio_route <= 32'h0000_0000;
        end else if (cw && ADDR_IN[15:2] == OFS_GPIO[15:2]) begin
            gpio_route[ADDR_IN[1:0]*8 +: 8] <= WDATA_IN;
        end
    end

    // fixed i/o ports; scratch byte touched by nothing else
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            cmd_port    <= 8'h00;
            scr_port    <= 8'h00;
            CMD_SMI_OUT <= 1'b0;
        end else begin
            CMD_SMI_OUT <= iw && ADDR_IN == IO_CMD && CMD_PORT_EN_IN; // RL21
            if (iw && ADDR_IN == IO_CMD) begin
                cmd_port <= WDATA_IN; // RL21
            end
            if (iw && ADDR_IN == IO_SCR) begin
                scr_port <= WDATA_IN; // RL22
            end
        end
    end

    // reset port decode
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            HOST_RESET_OUT   <= 1'b0;
            GLOBAL_RESET_OUT <= 1'b0;
        end else begin
            HOST_RESET_OUT <= iw && ADDR_IN == IO_RST &&
                (WDATA_IN == RST_CMD_A || WDATA_IN == RST_CMD_B);
            GLOBAL_RESET_OUT <= iw && ADDR_IN == IO_RST && glob_sel &&
                (WDATA_IN == RST_CMD_A || WDATA_IN == RST_CMD_B); // RL17
        end
    end

    // ==========
    // read path: one cycle, unmapped reads as zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (CFG_RD_IN) begin
            unique case (ADDR_IN)
                OFS_CFG3: rd_mux = {2'b00, s4_fld, 3'b000};
                OFS_LOCK: rd_mux = lock_ctl;
                OFS_DEEP: rd_mux = deep_t;
                OFS_MODE: rd_mux = mode_cfg;
                OFS_C4:   rd_mux = c4_t;
                OFS_BRK:  rd_mux = brk_en;
                OFS_INIT: rd_mux = {6'h00, init_f0};
                OFS_INIT + 16'h0002: rd_mux = {3'b000, glob_sel, 4'h0};
                OFS_INIT + 16'h0003: rd_mux = {rp_lock, init_f2, 6'h00};
                default: begin
                    if (ADDR_IN[15:2] == OFS_GPIO[15:2]) begin
                        rd_mux = gpio_route[ADDR_IN[1:0]*8 +: 8];
                    end
                end
            endcase
        end else if (IO_RD_IN) begin
            if (ADDR_IN == IO_CMD) begin
                rd_mux = cmd_port;
            end else if (ADDR_IN == IO_SCR) begin
                rd_mux = scr_port;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            RDATA_OUT  <= 8'h00;
            RVALID_OUT <= 1'b0;
        end else begin
            RDATA_OUT  <= rd_mux;
            RVALID_OUT <= CFG_RD_IN | IO_RD_IN;
        end
    end

    assign CSTATE_LOCK_OUT = lock_ctl[LCK_CST]; // RL4
    assign BASE_LOCK_OUT   = lock_ctl[LCK_BASE]; // RL3
    assign S4_WIDTH_OUT    = s4_fld[2:1];
    assign S4_STRETCH_OUT  = s4_fld[0];

    // ==========
    // bus master popup / popdown / break
    logic any_bm;
    logic brk_hit;
    logic in_c34;
    assign any_bm  = |BM_REQ_IN;
    assign brk_hit = |(BM_REQ_IN & brk_en);
    assign in_c34  = CPU_CSTATE_IN == 3'h3 || CPU_CSTATE_IN == 3'h4;

    // an enabled source breaks even with suppress and popup set
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            BM_FLAG_SET_OUT <= 1'b0;
            BREAK_C0_OUT    <= 1'b0;
            POPUP_C2_OUT    <= 1'b0;
            POPDOWN_OUT     <= 1'b0;
            BM_AUTO_EN_OUT  <= 1'b0;
        end else begin
            BM_FLAG_SET_OUT <= (any_bm && !mode_cfg[MODE_SUPP]) ||
                brk_hit; // RL11 RL15
            BREAK_C0_OUT <= in_c34 &&
                (brk_hit || (any_bm && !mode_cfg[MODE_PUP])); // RL8 RL15
            POPUP_C2_OUT <= in_c34 && any_bm && mode_cfg[MODE_PUP] &&
                !brk_hit; // RL8
            // popdown only from a popped-up C2; RL10 kept by software
            POPDOWN_OUT <= BM_AUTO_EN_OUT && mode_cfg[MODE_PDN] &&
                !any_bm && CPU_CSTATE_IN == 3'h2; // RL9
            if (in_c34 && any_bm && mode_cfg[MODE_PUP] && !brk_hit) begin
                BM_AUTO_EN_OUT <= 1'b1; // RL8
            end else if (POPDOWN_OUT || CPU_CSTATE_IN == 3'h0) begin
                BM_AUTO_EN_OUT <= 1'b0;
            end
        end
    end

    // ==========
    // gpio routing to smi / sci / wake
    logic [15:0] smi_v;
    logic [15:0] sci_v;
    logic [15:0] wake_v;
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_route
            logic act;
            assign act = GPIO_STS_IN[g] & GPIO_IS_INPUT_IN[g];
            assign smi_v[g] = act && gpio_route[2*g +: 2] == 2'b01 &&
                ALT_SMI_EN_IN[g]; // RL19
            assign sci_v[g] = act && gpio_route[2*g +: 2] == 2'b10 &&
                GPE_EN_IN[g]; // RL19
            assign wake_v[g] = act && SLEEPING_IN && GPE_EN_IN[g]; // RL20
        end
    endgenerate

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            GPIO_SMI_OUT  <= 1'b0;
            GPIO_SCI_OUT  <= 1'b0;
            GPIO_WAKE_OUT <= 1'b0;
        end else begin
            GPIO_SMI_OUT  <= |smi_v;
            GPIO_SCI_OUT  <= |sci_v;
            GPIO_WAKE_OUT <= |wake_v;
        end
    end

    // ==========
    // sleep sideband exit sequencer
    pmc_seq_e    state;
    logic        deep_mode;
    logic [15:0] cnt;
    logic [15:0] first_dly;
    logic [15:0] dly_a;
    logic [15:0] dly_b;

    // fast exits skip the first wait: one cycle instead
    always_comb begin
        if (deep_mode) begin
            dly_a = deep_t.slow ? us_cyc(DSTOP_US[deep_t.stop_dly])
                                : 16'h0001; // RL5 RL7
            dly_b = deep_t.sync_dly == 3'h0 ? 16'(SYNC_PCI_CYC)
                  : us_cyc(SYNC_US[deep_t.sync_dly]); // RL6
        end else begin
            dly_a = (c4_t.force_slow || c4_t.slow)
                  ? us_cyc(VREG_US[c4_t.vr_dly]) : 16'h0001; // RL12 RL13
            dly_b = c4_t.msg_dly == 2'h0 ? us_cyc(PLL_US[PLL_LOCK_TIME_IN])
                  : us_cyc(MSG_US[c4_t.msg_dly]); // RL14
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            state               <= ST_AWAKE;
            deep_mode           <= 1'b0;
            cnt                 <= 16'h0000;
            first_dly           <= 16'h0000;
            POWER_SYNC_N_OUT    <= 1'b1;
            STOP_CLOCK_N_OUT    <= 1'b1;
            DEEPER_STOP_N_OUT   <= 1'b1;
            STOP_CPU_N_OUT      <= 1'b1;
            REGULATOR_SLEEP_OUT <= 1'b0;
            DEEP_SLEEP_N_OUT    <= 1'b1;
            MEM_MSG_OUT         <= 1'b0;
        end else begin
            MEM_MSG_OUT <= 1'b0;
            if (state != ST_AWAKE && state != ST_SLEEP) begin
                cnt <= cnt - 16'h0001;
            end
            unique case (state)
                ST_AWAKE: begin
                    if (CX_ENTER_IN) begin
                        deep_mode           <= CX_DEEP_IN;
                        STOP_CLOCK_N_OUT    <= 1'b0;
                        STOP_CPU_N_OUT      <= 1'b0;
                        DEEP_SLEEP_N_OUT    <= 1'b0;
                        REGULATOR_SLEEP_OUT <= 1'b1;
                        DEEPER_STOP_N_OUT   <= 1'b0;
                        POWER_SYNC_N_OUT    <= !CX_DEEP_IN;
                        state               <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (CX_EXIT_IN) begin
                        cnt       <= dly_a;
                        first_dly <= dly_a;
                        state     <= ST_EXIT1;
                        if (deep_mode) begin
                            DEEPER_STOP_N_OUT <= 1'b1; // RL7
                        end else begin
                            REGULATOR_SLEEP_OUT <= 1'b0; // RL13
                        end
                    end
                end
                ST_EXIT1: begin
                    if (cnt == 16'h0001) begin
                        STOP_CPU_N_OUT      <= 1'b1; // RL7 RL13
                        DEEP_SLEEP_N_OUT    <= 1'b1;
                        REGULATOR_SLEEP_OUT <= 1'b0;
                        DEEPER_STOP_N_OUT   <= 1'b1;
                        POWER_SYNC_N_OUT    <= 1'b1; // RL6
                        cnt                 <= dly_b;
                        state               <= ST_EXIT2;
                    end
                end
                ST_EXIT2: begin
                    if (cnt == 16'h0001) begin
                        STOP_CLOCK_N_OUT <= 1'b1; // RL6
                        MEM_MSG_OUT      <= !deep_mode; // RL14
                        state            <= ST_AWAKE;
                    end
                end
            endcase
        end
    end

    // ==========
    // checks
    logic [15:0] gap;
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN || state != ST_EXIT1) begin
            gap <= 16'h0000;
        end else begin
            gap <= gap + 16'h0001;
        end
    end

    sequence s_cmd_wr;
        IO_WR_IN && ADDR_IN == IO_CMD && CMD_PORT_EN_IN;
    endsequence
    sequence s_first_done;
        $rose(STOP_CPU_N_OUT) && state == ST_EXIT2;
    endsequence

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_unlock_flag: assert property ( // RL1
        CPU_CSTATE_IN > 3'h2 && !lock_ctl[LCK_CST] |=> lock_ctl[LCK_UNL])
        else $error("unlocked flag not set");
    a_s4_frozen: assert property ( // RL2
        lock_ctl[LCK_S4] && cw && ADDR_IN == OFS_CFG3 |=> $stable(s4_fld))
        else $error("s4 fields changed under lock");
    a_base_sticky: assert property ( // RL3
        lock_ctl[LCK_BASE] |=> lock_ctl[LCK_BASE] && BASE_LOCK_OUT)
        else $error("base lock dropped");
    a_c4_frozen: assert property ( // RL4
        lock_ctl[LCK_CST] && cw |=> $stable(c4_t) && $stable(deep_t))
        else $error("timing changed under lock");
    a_exit_wait: assert property ( // RL7
        s_first_done |-> gap == first_dly && REGULATOR_SLEEP_OUT == 1'b0)
        else $error("first exit wait wrong length");
    a_popdown_off: assert property ( // RL9
        !mode_cfg[MODE_PDN] |=> !POPDOWN_OUT)
        else $error("popdown while disabled");
    a_break_flag: assert property ( // RL15
        brk_hit |=> BM_FLAG_SET_OUT ##0 (BREAK_C0_OUT || !$past(in_c34)))
        else $error("enabled source did not break");
    a_suppress: assert property ( // RL11
        any_bm && mode_cfg[MODE_SUPP] && !brk_hit |=> !BM_FLAG_SET_OUT)
        else $error("flag set while suppressed");
    a_cmd_smi: assert property ( // RL21
        s_cmd_wr |=> CMD_SMI_OUT && cmd_port == $past(WDATA_IN))
        else $error("command write lost");
    a_glob_reset: assert property ( // RL17
        HOST_RESET_OUT && $past(glob_sel) |-> GLOBAL_RESET_OUT)
        else $error("global reset not widened");
endmodule : pmc_regs
`default_nettype wire

// ### test_pmc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_pmc_regs;
    import pmc_pkg::*;
    // ==========
    // stimulus, named as the ports
    logic MCLK_IN = 1'b0, RST_N_IN = 1'b0, CFG_WR_IN = 1'b0, CFG_RD_IN = 1'b0;
    logic IO_WR_IN = 1'b0, IO_RD_IN = 1'b0, RST_PORT_RESET_IN = 1'b0;
    logic CX_ENTER_IN = 1'b0, CX_DEEP_IN = 1'b0, CX_EXIT_IN = 1'b0;
    logic CMD_PORT_EN_IN = 1'b0, SLEEPING_IN = 1'b0;
    logic [15:0] ADDR_IN = 16'h0000, GPIO_STS_IN = 16'h0000;
    logic [15:0] GPIO_IS_INPUT_IN = 16'h0000, ALT_SMI_EN_IN = 16'h0000;
    logic [15:0] GPE_EN_IN = 16'h0000, gap_a, gap_b;
    logic [7:0]  WDATA_IN = 8'h00, BM_REQ_IN = 8'h00, d, RDATA_OUT;
    logic [2:0]  CPU_CSTATE_IN = 3'h0;
    logic [1:0]  PLL_LOCK_TIME_IN = 2'h0, S4_WIDTH_OUT;
    logic RVALID_OUT, S4_STRETCH_OUT, BM_FLAG_SET_OUT, BREAK_C0_OUT;
    logic POPUP_C2_OUT, DEEPER_STOP_N_OUT, STOP_CPU_N_OUT, STOP_CLOCK_N_OUT;
    logic CMD_SMI_OUT, GPIO_SMI_OUT, GPIO_SCI_OUT, GPIO_WAKE_OUT;
    logic HOST_RESET_OUT, GLOBAL_RESET_OUT;
    int errors = 0, total_checks = 0, seed, i, k, n_smi = 0, n_hst = 0;
    int n_glb = 0;
    logic [7:0] modes [4] = '{8'h00, 8'h08, 8'h0C, 8'h0C};
    logic [7:0] brks [4] = '{8'h00, 8'h00, 8'h00, 8'h20};
    logic [1:0] expb [4] = '{2'h3, 2'h1, 2'h0, 2'h3};

    pmc_regs pmc_regs_i (.MCLK_IN, .RST_N_IN, .CFG_WR_IN, .CFG_RD_IN,
        .IO_WR_IN, .IO_RD_IN, .ADDR_IN, .WDATA_IN, .RST_PORT_RESET_IN,
        .CPU_CSTATE_IN, .BM_REQ_IN, .CX_ENTER_IN, .CX_DEEP_IN, .CX_EXIT_IN,
        .PLL_LOCK_TIME_IN, .CMD_PORT_EN_IN, .GPIO_STS_IN, .GPIO_IS_INPUT_IN,
        .ALT_SMI_EN_IN, .GPE_EN_IN, .SLEEPING_IN, .RDATA_OUT, .RVALID_OUT,
        .CSTATE_LOCK_OUT(), .BASE_LOCK_OUT(), .S4_WIDTH_OUT, .S4_STRETCH_OUT,
        .BM_FLAG_SET_OUT, .BREAK_C0_OUT, .POPUP_C2_OUT, .POPDOWN_OUT(),
        .BM_AUTO_EN_OUT(), .POWER_SYNC_N_OUT(), .STOP_CLOCK_N_OUT,
        .DEEPER_STOP_N_OUT, .STOP_CPU_N_OUT, .REGULATOR_SLEEP_OUT(),
        .DEEP_SLEEP_N_OUT(), .MEM_MSG_OUT(), .CMD_SMI_OUT, .GPIO_SMI_OUT,
        .GPIO_SCI_OUT, .GPIO_WAKE_OUT, .HOST_RESET_OUT, .GLOBAL_RESET_OUT);
    pmc_cpu_model pmc_cpu_model_i (.clk_in(MCLK_IN),
        .dstop_n_in(DEEPER_STOP_N_OUT), .scpu_n_in(STOP_CPU_N_OUT),
        .sclk_n_in(STOP_CLOCK_N_OUT), .gap_a_out(gap_a), .gap_b_out(gap_b));

    // clock, and pulse counters so short pulses are never missed
    initial forever #5 MCLK_IN = ~MCLK_IN;
    always @(posedge MCLK_IN) begin
        n_smi += int'(CMD_SMI_OUT);
        n_hst += int'(HOST_RESET_OUT);
        n_glb += int'(GLOBAL_RESET_OUT);
    end
    // ==========
    // shared tasks and expectations
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic w, io, input logic [15:0] a,
                       input logic [7:0] v);
        @(posedge MCLK_IN);
        ADDR_IN <= a;
        WDATA_IN <= v;
        {CFG_WR_IN, IO_WR_IN, CFG_RD_IN, IO_RD_IN} <= {w&!io, w&io, !w&!io, !w&io};
        @(posedge MCLK_IN);
        {CFG_WR_IN, IO_WR_IN, CFG_RD_IN, IO_RD_IN} <= 4'h0;
    endtask : acc
    task automatic rd(input logic io, input logic [15:0] a, input logic [7:0] e);
        acc(1'b0, io, a, 8'h00);
        #1;
        chk({7'h00, RVALID_OUT, RDATA_OUT}, {8'h01, e});
    endtask : rd
    task automatic settle;
        repeat (3) @(posedge MCLK_IN);
        #1;
    endtask : settle
    function automatic logic [15:0] n1(input logic [7:0] v);
        return v[6] ? 16'(DSTOP_US[v[2:0]] * 100) : 16'h0001;
    endfunction : n1
    function automatic logic [15:0] n2(input logic [7:0] v);
        return v[5:3] == 3'h0 ? 16'h0030 : 16'(SYNC_US[v[5:3]] * 100);
    endfunction : n2
    task automatic give_verdict;
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // hang guard, well past the longest exit wait
    initial begin
        #500000;
        errors++;
        give_verdict();
    end
    // ==========
    // main sequence
    initial begin
        seed = 30466;
        repeat (6) @(posedge MCLK_IN);
        RST_N_IN <= 1'b1;
        rd(0, OFS_DEEP, DEEP_RST);
        rd(1, IO_SCR, 8'h00);
        for (i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            acc(1, 0, OFS_BRK, d);
            rd(0, OFS_BRK, d & BRK_MASK);
            acc(1, 1, IO_SCR, d);
            rd(1, IO_SCR, d);
        end
        acc(1, 0, OFS_C4, 8'hC5);
        acc(1, 0, OFS_INIT, 8'h03);
        CMD_PORT_EN_IN <= 1'b1;
        k = n_smi;
        acc(1, 1, IO_CMD, 8'hA5);
        settle();
        @(posedge MCLK_IN);
        CMD_PORT_EN_IN <= 1'b0;
        acc(1, 1, IO_CMD, 8'h3C);
        settle();
        chk(16'(n_smi - k), 16'h0001);
        rd(1, IO_CMD, 8'h3C);
        CPU_CSTATE_IN <= 3'h3;
        for (i = 0; i < 4; i++) begin
            acc(1, 0, OFS_BRK, brks[i]);
            acc(1, 0, OFS_MODE, modes[i]);
            BM_REQ_IN <= 8'h20;
            @(posedge MCLK_IN);
            #1;
            chk({14'h0, BREAK_C0_OUT, BM_FLAG_SET_OUT}, 16'(expb[i]));
            if (i == 1) chk({15'h0, POPUP_C2_OUT}, 16'h0001);
            @(posedge MCLK_IN);
            BM_REQ_IN <= 8'h00;
        end
        rd(0, OFS_LOCK, 8'h80);
        CPU_CSTATE_IN <= 3'h0;
        for (i = 0; i < 2; i++) begin
            d = i ? 8'h66 : 8'h40;
            acc(1, 0, OFS_DEEP, d);
            CX_DEEP_IN <= 1'b1;
            CX_ENTER_IN <= 1'b1;
            @(posedge MCLK_IN);
            CX_ENTER_IN <= 1'b0;
            repeat (4) @(posedge MCLK_IN);
            CX_EXIT_IN <= 1'b1;
            @(posedge MCLK_IN);
            CX_EXIT_IN <= 1'b0;
            repeat (int'(n1(d)) + int'(n2(d)) + 20) @(posedge MCLK_IN);
            chk(gap_a, n1(d));
            chk(gap_b, n2(d));
        end
        acc(1, 0, OFS_LOCK, 8'h00);
        rd(0, OFS_LOCK, 8'h80);
        acc(1, 0, OFS_CFG3, 8'h38);
        acc(1, 0, OFS_LOCK, 8'h07);
        acc(1, 0, OFS_CFG3, 8'h00);
        acc(1, 0, OFS_DEEP, 8'h00);
        acc(1, 0, OFS_C4, 8'h00);
        rd(0, OFS_LOCK, 8'h87);
        rd(0, OFS_DEEP, 8'h66);
        rd(0, OFS_C4, 8'hC5);
        rd(0, OFS_CFG3, 8'h38);
        chk({13'h0, S4_WIDTH_OUT, S4_STRETCH_OUT}, 16'h0007);
        acc(1, 0, OFS_INIT + 16'h0002, 8'h10);
        k = n_hst;
        i = n_glb;
        acc(1, 1, IO_RST, RST_CMD_B);
        settle();
        chk(16'(n_hst - k), 16'h0001);
        chk(16'(n_glb - i), 16'h0001);
        acc(1, 0, OFS_INIT + 16'h0003, 8'hC0);
        acc(1, 0, OFS_INIT + 16'h0003, 8'h40);
        acc(1, 0, OFS_INIT + 16'h0002, 8'h00);
        rd(0, OFS_INIT + 16'h0003, 8'hC0);
        rd(0, OFS_INIT + 16'h0002, 8'h10);
        @(posedge MCLK_IN);
        RST_PORT_RESET_IN <= 1'b1;
        @(posedge MCLK_IN);
        RST_PORT_RESET_IN <= 1'b0;
        acc(1, 0, OFS_INIT + 16'h0003, 8'h00);
        rd(0, OFS_INIT + 16'h0003, 8'h00);
        rd(0, OFS_INIT + 16'h0002, 8'h10);
        @(posedge MCLK_IN);
        GPIO_IS_INPUT_IN <= 16'h0003;
        GPIO_STS_IN <= 16'h0003;
        ALT_SMI_EN_IN <= 16'h0001;
        GPE_EN_IN <= 16'h0002;
        acc(1, 0, OFS_GPIO, 8'h09);
        settle();
        chk({14'h0, GPIO_SMI_OUT, GPIO_SCI_OUT}, 16'h0003);
        @(posedge MCLK_IN);
        SLEEPING_IN <= 1'b1;
        acc(1, 0, OFS_GPIO, 8'h00);
        settle();
        chk({13'h0, GPIO_SMI_OUT, GPIO_SCI_OUT, GPIO_WAKE_OUT}, 16'h0001);
        @(posedge MCLK_IN);
        RST_N_IN <= 1'b0;
        repeat (2) @(posedge MCLK_IN);
        RST_N_IN <= 1'b1;
        rd(0, OFS_LOCK, 8'h00);
        rd(1, IO_SCR, 8'h00);
        give_verdict();
    end
endmodule : test_pmc_regs
`default_nettype wire
